// ### memctl_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the memory
 * bank controller. Assumes inclusion by bare name from the design file.
 */
`ifndef MEMCTL_PARAMS_SVH
`define MEMCTL_PARAMS_SVH

`define OFF_WIDTH 8'h00
`define OFF_STATIC0 8'h04
`define OFF_SDRAM6 8'h1c
`define OFF_REFRESH 8'h24
`define OFF_SIZE 8'h28
`define OFF_MODE6 8'h2c
`define OFF_STATUS 8'h34

`define RST_WIDTH 32'h0000_0000
`define RST_STATIC 32'h0000_0700
`define RST_SDRAM 32'h0000_0000
`define RST_REFRESH 32'h0000_0000
`define RST_SIZE 32'h0000_0000
`define RST_MODE 32'h0000_0030

`define BOOT_ADDR 30'h0000_0000
`define ACC_LSB 8
`define ACC_MSB 10
`define TRCD_LSB 2
`define TRCD_MSB 3
`define FOUR_BANK_BIT 4
`define SIZE_MSB 2
`define CL_LSB 4
`define CL_MSB 6
`define TRCD_BASE 3'h2
`define BOOT_SETTLE 2'h3

`endif

// ### memctl_pkg.sv
/*
 * Types shared by the memory bank controller.
 * Assumes nothing of its surroundings.
 */
package memctl_pkg;
    typedef enum logic [2:0] {
        S_WAIT = 3'h0,
        S_IDLE = 3'h1,
        S_STATIC = 3'h3,
        S_ACT = 3'h2,
        S_COL = 3'h6,
        S_DONE = 3'h7
    } state_type;
    typedef enum logic [1:0] {
        W_BYTE = 2'h0,
        W_HALF = 2'h1,
        W_WORD = 2'h2
    } width_type;
endpackage

// ### memory_bank_boot_config.sv
/*
 * External memory bank controller: APB register file, boot fetch from
 * address zero, six static banks and two SDRAM-capable banks.
 * Assumes a single-cycle-domain core request port and asynchronous pins.
 */
// The register addresses and the APB interface to the registers were left to the implementer.
// Contract
// RL1 - After reset the first fetch is from address zero.
// RL2 - Boot mode pins pick bank zero width: NAND, 16, 32, test.
// RL3 - Halfword boot bank: big endian odd bytes low lane; little reversed.
// RL4 - Eight banks: six static only, banks six and seven also SDRAM. The code runs banks six and seven as SDRAM only.
// RL5 - Software sets access timing per bank in its own timing register.
// RL6 - Bank zero width comes from boot pins, never from software.
// RL7 - Banks one to seven take software-selected byte, half or word width.
// RL8 - Boot code programs all memory registers before non-boot accesses.
// RL9 - SDRAM bank-select bits follow bank size and bank count.
// RL10 - 64MB uses A[25:24], 128MB uses A[26:25].
// RL11 - Recommended refresh: enabled, precharge 2, cycle 7, hold 3, 1113. The code only stores the refresh register and issues no refresh.
// RL12 - Drive SDRAM clock enable, clock, selects, strobes, masks, AP.
// RL13 - Only the addressed bank selects, with its width and timing.
// RL14 - Bank-select bits go to SDRAM bank pins on activate and column.
`include "memctl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module memory_bank_boot_config
    import memctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] boot_mode_pins,
    input wire logic big_endian,
    input wire logic [31:0] mem_data_in,
    input wire logic req,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic [29:0] req_addr,
    output logic ack,
    output logic [31:0] rdata,
    output logic [26:0] mem_addr,
    output logic [5:0] static_cs_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic [1:0] sdram_chip_selects_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic [3:0] byte_mask_n,
    output logic [1:0] sdram_bank_addr,
    output logic sdram_clk_en,
    output logic sdram_clk,
    output logic auto_precharge_flag
);
    function automatic logic [3:0] acc_cycles(input logic [2:0] code);
        case (code)
            3'h0: acc_cycles = 4'h1;
            3'h1: acc_cycles = 4'h2;
            3'h2: acc_cycles = 4'h3;
            3'h3: acc_cycles = 4'h4;
            3'h4: acc_cycles = 4'h6;
            3'h5: acc_cycles = 4'h8;
            3'h6: acc_cycles = 4'ha;
            default: acc_cycles = 4'he;
        endcase
    endfunction

    // Two-bank parts use one bit at 20+size, four-bank parts it and the next
    // lower bit
    function automatic logic [1:0] bank_sel(input logic [2:0] size,
        input logic four, input logic [29:0] a);
        logic [4:0] idx;
        idx = 5'(20 + size);
        if (four)
            bank_sel = {a[idx], a[idx - 5'h1]}; // RL9 RL10
        else
            bank_sel = {1'b0, a[idx]}; // RL9
    endfunction

    function automatic logic [3:0] lane_mask(input width_type w);
        case (w)
            W_BYTE: lane_mask = 4'he;
            W_HALF: lane_mask = 4'hc;
            default: lane_mask = 4'h0;
        endcase
    endfunction

    logic [1:0] mode_s1, mode_s2;
    logic endian_s1, endian_s2;
    logic [31:0] data_s1, data_s2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_s1 <= 2'h0;
            mode_s2 <= 2'h0;
            endian_s1 <= 1'b0;
            endian_s2 <= 1'b0;
            data_s1 <= 32'h0;
            data_s2 <= 32'h0;
        end else begin
            mode_s1 <= boot_mode_pins;
            mode_s2 <= mode_s1;
            endian_s1 <= big_endian;
            endian_s2 <= endian_s1;
            data_s1 <= mem_data_in;
            data_s2 <= data_s1;
        end
    end

    // Register file
    logic [31:0] width_reg, width_next;
    logic [31:0] static_reg [6];
    logic [31:0] static_next [6];
    logic [31:0] sdram_reg [2];
    logic [31:0] sdram_next [2];
    logic [31:0] mode_reg [2];
    logic [31:0] mode_next [2];
    logic [31:0] refresh_reg, refresh_next, size_reg, size_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    logic [5:0] status_bits;
    logic apb_go;
    assign apb_go = psel && penable && pready;

    always_comb begin
        width_next = width_reg;
        refresh_next = refresh_reg;
        size_next = size_reg;
        static_next = static_reg;
        sdram_next = sdram_reg;
        mode_next = mode_reg;
        prdata_next = 32'h0;
        pslverr_next = 1'b0;
        pready_next = psel && penable && !pready;
        for (int i = 0; i < 6; i++) begin
            if (paddr == 8'(`OFF_STATIC0 + 4 * i)) begin
                if (apb_go && pwrite)
                    static_next[i] = pwdata; // RL5
                prdata_next = static_reg[i];
            end
        end
        for (int j = 0; j < 2; j++) begin
            if (paddr == 8'(`OFF_SDRAM6 + 4 * j)) begin
                if (apb_go && pwrite)
                    sdram_next[j] = pwdata; // RL5
                prdata_next = sdram_reg[j];
            end
            if (paddr == 8'(`OFF_MODE6 + 4 * j)) begin
                if (apb_go && pwrite)
                    mode_next[j] = pwdata;
                prdata_next = mode_reg[j];
            end
        end
        case (paddr)
            `OFF_WIDTH: begin
                if (apb_go && pwrite)
                    width_next = {pwdata[31:4], 4'h0}; // RL6
                prdata_next = width_reg;
            end
            `OFF_REFRESH: begin
                if (apb_go && pwrite)
                    refresh_next = pwdata;
                prdata_next = refresh_reg;
            end
            `OFF_SIZE: begin
                if (apb_go && pwrite)
                    size_next = pwdata;
                prdata_next = size_reg;
            end
            `OFF_STATUS: prdata_next = {26'h0, status_bits};
            default: begin
                if (paddr[1:0] != 2'h0 || paddr > `OFF_STATUS)
                    pslverr_next = pready_next;
            end
        endcase
        if (!pready_next)
            prdata_next = 32'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_reg <= `RST_WIDTH;
            refresh_reg <= `RST_REFRESH;
            size_reg <= `RST_SIZE;
            static_reg <= '{default: `RST_STATIC};
            sdram_reg <= '{default: `RST_SDRAM};
            mode_reg <= '{default: `RST_MODE};
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            width_reg <= width_next;
            refresh_reg <= refresh_next;
            size_reg <= size_next;
            static_reg <= static_next;
            sdram_reg <= sdram_next;
            mode_reg <= mode_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
        end
    end

    // Access engine
    state_type state_reg, state_next;
    width_type boot_width_reg, boot_width_next, cur_width;
    logic [1:0] boot_mode_reg, boot_mode_next;
    logic [29:0] addr_reg, addr_next;
    logic [2:0] bank_reg, bank_next;
    logic [3:0] cnt_reg, cnt_next;
    logic boot_reg, boot_next, wr_reg, wr_next, byte_reg, byte_next;
    logic boot_done_reg, boot_done_next, ack_next, clk_next;
    logic [31:0] rdata_next;
    logic [5:0] static_cs_next;
    logic [1:0] sdram_cs_next, bank_addr_next;
    logic [26:0] mem_addr_next;
    logic ras_next, cas_next, oe_next, we_next, ap_next, cke_next;
    logic [3:0] mask_next;
    logic [1:0] sd;

    assign sd = 2'(bank_reg - 3'h6);
    assign status_bits = {boot_mode_reg, boot_width_reg, state_reg == S_IDLE,
        boot_done_reg};
    assign cur_width = (bank_reg == 3'h0) ? boot_width_reg : // RL6
        width_type'(width_reg[4 * bank_reg +: 2]); // RL7

    always_comb begin
        state_next = state_reg;
        boot_width_next = boot_width_reg;
        boot_mode_next = boot_mode_reg;
        addr_next = addr_reg;
        bank_next = bank_reg;
        cnt_next = cnt_reg;
        boot_next = boot_reg;
        wr_next = wr_reg;
        byte_next = byte_reg;
        boot_done_next = boot_done_reg;
        ack_next = 1'b0;
        rdata_next = rdata;
        clk_next = ~sdram_clk;
        static_cs_next = 6'h3f;
        sdram_cs_next = 2'h3;
        ras_next = 1'b1;
        cas_next = 1'b1;
        oe_next = 1'b1;
        we_next = 1'b1;
        ap_next = 1'b0;
        cke_next = 1'b1; // RL12
        mask_next = 4'hf;
        bank_addr_next = sdram_bank_addr;
        mem_addr_next = mem_addr;
        case (state_reg)
            S_WAIT: begin
                cnt_next = 4'(cnt_reg + 4'h1);
                if (cnt_reg[1:0] == `BOOT_SETTLE) begin
                    boot_mode_next = mode_s2;
                    case (mode_s2)
                        2'h0: boot_width_next = W_BYTE; // RL2
                        2'h1: boot_width_next = W_HALF; // RL2
                        default: boot_width_next = W_WORD; // RL2
                    endcase
                    addr_next = `BOOT_ADDR; // RL1
                    bank_next = 3'h0;
                    boot_next = 1'b1;
                    wr_next = 1'b0;
                    byte_next = 1'b0;
                    cnt_next = acc_cycles(static_reg[0][`ACC_MSB:`ACC_LSB]);
                    state_next = S_STATIC;
                end
            end
            S_IDLE: begin
                if (req && !ack) begin
                    addr_next = req_addr;
                    bank_next = req_addr[29:27];
                    wr_next = req_write;
                    byte_next = req_byte;
                    boot_next = 1'b0;
                    if (req_addr[29:28] == 2'h3) begin // RL4
                        cnt_next = 4'(`TRCD_BASE +
                            sdram_reg[req_addr[27]][`TRCD_MSB:`TRCD_LSB]);
                        state_next = S_ACT;
                    end else begin
                        cnt_next = acc_cycles(static_reg[req_addr[29:27]]
                            [`ACC_MSB:`ACC_LSB]); // RL5
                        state_next = S_STATIC;
                    end
                end
            end
            S_STATIC: begin
                static_cs_next[bank_reg] = 1'b0; // RL13
                mem_addr_next = addr_reg[26:0];
                oe_next = wr_reg;
                we_next = !wr_reg;
                mask_next = lane_mask(cur_width); // RL7
                cnt_next = 4'(cnt_reg - 4'h1);
                if (cnt_reg == 4'h1) begin
                    rdata_next = data_s2;
                    if (cur_width == W_HALF && byte_reg)
                        rdata_next = {24'h0, (addr_reg[0] ^ endian_s2) ?
                            data_s2[15:8] : data_s2[7:0]}; // RL3
                    state_next = S_DONE;
                end
            end
            S_ACT: begin
                if (cnt_reg == 4'(`TRCD_BASE +
                    sdram_reg[sd[0]][`TRCD_MSB:`TRCD_LSB])) begin
                    sdram_cs_next[sd[0]] = 1'b0; // RL13
                    ras_next = 1'b0;
                    bank_addr_next = bank_sel(size_reg[`SIZE_MSB:0],
                        sdram_reg[sd[0]][`FOUR_BANK_BIT], addr_reg); // RL14
                    mem_addr_next = {14'h0, addr_reg[22:10]};
                end
                cnt_next = 4'(cnt_reg - 4'h1);
                if (cnt_reg == 4'h0) begin
                    cnt_next = 4'(mode_reg[sd[0]][`CL_MSB:`CL_LSB]);
                    sdram_cs_next[sd[0]] = 1'b0;
                    cas_next = 1'b0;
                    we_next = !wr_reg;
                    ap_next = 1'b1; // RL12
                    bank_addr_next = bank_sel(size_reg[`SIZE_MSB:0],
                        sdram_reg[sd[0]][`FOUR_BANK_BIT], addr_reg); // RL14
                    mem_addr_next = {14'h0, 1'b1, 3'h0, addr_reg[9:1]};
                    mask_next = lane_mask(cur_width);
                    state_next = S_COL;
                end
            end
            S_COL: begin
                mask_next = lane_mask(cur_width);
                cnt_next = 4'(cnt_reg - 4'h1);
                if (cnt_reg <= 4'h1) begin
                    rdata_next = data_s2;
                    state_next = S_DONE;
                end
            end
            S_DONE: begin
                ack_next = !boot_reg;
                boot_done_next = 1'b1;
                state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_WAIT;
            boot_width_reg <= W_BYTE;
            boot_mode_reg <= 2'h0;
            addr_reg <= 30'h0;
            bank_reg <= 3'h0;
            cnt_reg <= 4'h0;
            boot_reg <= 1'b0;
            wr_reg <= 1'b0;
            byte_reg <= 1'b0;
            boot_done_reg <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0;
            static_cs_n <= 6'h3f;
            sdram_chip_selects_n <= 2'h3;
            row_strobe_n <= 1'b1;
            column_strobe_n <= 1'b1;
            out_en_n <= 1'b1;
            write_en_n <= 1'b1;
            byte_mask_n <= 4'hf;
            sdram_bank_addr <= 2'h0;
            mem_addr <= 27'h0;
            auto_precharge_flag <= 1'b0;
            sdram_clk_en <= 1'b0;
            sdram_clk <= 1'b0;
        end else begin
            state_reg <= state_next;
            boot_width_reg <= boot_width_next;
            boot_mode_reg <= boot_mode_next;
            addr_reg <= addr_next;
            bank_reg <= bank_next;
            cnt_reg <= cnt_next;
            boot_reg <= boot_next;
            wr_reg <= wr_next;
            byte_reg <= byte_next;
            boot_done_reg <= boot_done_next;
            ack <= ack_next;
            rdata <= rdata_next;
            static_cs_n <= static_cs_next;
            sdram_chip_selects_n <= sdram_cs_next;
            row_strobe_n <= ras_next;
            column_strobe_n <= cas_next;
            out_en_n <= oe_next;
            write_en_n <= we_next;
            byte_mask_n <= mask_next;
            sdram_bank_addr <= bank_addr_next;
            mem_addr <= mem_addr_next;
            auto_precharge_flag <= ap_next;
            sdram_clk_en <= cke_next;
            sdram_clk <= clk_next;
        end
    end

    // Checks
    logic [3:0] low_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_cnt <= 4'h0;
        else
            low_cnt <= (&static_cs_n) ? 4'h0 : 4'(low_cnt + 4'h1);
    end

    chk_boot_first_addr: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        $fell(boot_done_reg == 1'b0 && state_reg == S_WAIT) |=>
        !static_cs_n[0] && mem_addr == 27'h0)
        else $error("boot fetch not at address zero");
    chk_boot_width_map: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        state_reg == S_STATIC && boot_reg |->
        boot_width_reg == ((boot_mode_reg == 2'h1) ? W_HALF :
        (boot_mode_reg == 2'h0) ? W_BYTE : W_WORD))
        else $error("bank zero width does not follow boot pins");
    chk_bank0_width_fixed: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        boot_done_reg |-> $stable(boot_width_reg))
        else $error("bank zero width changed after boot");
    chk_one_select: assert property (@(posedge pclk) disable iff (!presetn) // RL13
        $onehot0(~{static_cs_n, sdram_chip_selects_n}))
        else $error("more than one bank selected");
    chk_sdram_banks_only: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        !(&sdram_chip_selects_n) |-> bank_reg[2:1] == 2'h3)
        else $error("SDRAM select on a static bank");
    chk_act_then_col: assert property (@(posedge pclk) disable iff (!presetn) // RL14
        !row_strobe_n |-> ##[2:5] !column_strobe_n && auto_precharge_flag)
        else $error("column command missing after activate");
    chk_bank_bits_128: assert property (@(posedge pclk) disable iff (!presetn) // RL10
        !row_strobe_n && $past(size_reg[2:0]) == 3'h6 &&
        $past(sdram_reg[sd[0]][`FOUR_BANK_BIT]) |->
        sdram_bank_addr == addr_reg[26:25])
        else $error("128MB bank select not on A26:A25");
    chk_byte_lanes: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        !static_cs_n[1] && $past(width_reg[5:4]) == 2'h0 |-> byte_mask_n == 4'he)
        else $error("byte bank lane mask wrong");
    chk_static_len: assert property (@(posedge pclk) disable iff (!presetn) // RL5
        $rose(&static_cs_n) |->
        low_cnt == acc_cycles(static_reg[bank_reg][`ACC_MSB:`ACC_LSB]))
        else $error("static access length differs from timing");
endmodule
`default_nettype wire

// ### mem_model.sv
/*
 * Far-side memory model: static ROM/SRAM and SDRAM parts that answer
 * reads with fixed words. Assumes the controller's memory pins.
 */
`timescale 1ns/1ns
`default_nettype none
module mem_model #(
    parameter logic [31:0] STATIC_WORD = 32'ha1b2_c3d4,
    parameter logic [31:0] SDRAM_WORD = 32'h5e6f_7081,
    parameter int HOLD = 8
) (
    input wire logic pclk,
    input wire logic [5:0] static_cs_n,
    input wire logic out_en_n,
    input wire logic [1:0] sdram_chip_selects_n,
    output logic [31:0] mem_data_in
);
    int hold_count = 0;
    initial mem_data_in = 32'h0;
    // Released bus inverts its last word each cycle, after holding an SDRAM word for HOLD cycles
    always @(posedge pclk) begin
        if (static_cs_n !== 6'h3f && out_en_n === 1'b0) begin
            mem_data_in <= STATIC_WORD;
        end else if (sdram_chip_selects_n !== 2'h3) begin
            hold_count <= HOLD;
            mem_data_in <= SDRAM_WORD;
        end else if (hold_count > 0) begin
            hold_count <= hold_count - 1;
        end else begin
            mem_data_in <= ~mem_data_in;
        end
    end
endmodule
`default_nettype wire

// ### memory_bank_boot_config_tb_top.sv
/*
 * Bench for the memory bank controller: APB master, core requests and a
 * table of SDRAM bank-select cases. Assumes mem_model on the memory pins.
 */
`timescale 1ns/1ns
`default_nettype none
module memory_bank_boot_config_tb_top;
    localparam logic [31:0] STATIC_WORD = 32'ha1b2_c3d4;
    localparam logic [31:0] SDRAM_WORD = 32'h5e6f_7081;
    typedef struct packed {
        logic [2:0] size;
        logic four;
        logic [29:0] a;
        logic [1:0] ba;
    } row_type;
    row_type rows[10] = '{
        '{3'h0, 1'b1, 30'h3010_0000, 2'h2}, '{3'h1, 1'b1, 30'h3020_0000, 2'h2},
        '{3'h2, 1'b1, 30'h3040_0000, 2'h2}, '{3'h3, 1'b1, 30'h3080_0000, 2'h2},
        '{3'h4, 1'b1, 30'h3100_0000, 2'h2}, '{3'h5, 1'b1, 30'h3100_0000, 2'h1},
        '{3'h6, 1'b1, 30'h3200_0000, 2'h1}, '{3'h1, 1'b1, 30'h3010_0000, 2'h1},
        '{3'h0, 1'b0, 30'h3010_0000, 2'h1}, '{3'h2, 1'b0, 30'h3840_0000, 2'h1}};
    logic [31:0] acc_cycles[8] = '{32'h1, 32'h2, 32'h3, 32'h4,
        32'h6, 32'h8, 32'ha, 32'he};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic req = 1'b0;
    logic req_byte = 1'b0;
    logic req_write = 1'b0;
    logic we_seen;
    logic big_endian = 1'b0;
    logic [1:0] boot_pins = 2'h0;
    logic [29:0] req_addr = 30'h0;
    logic [31:0] prdata, rdata, mem_data_in, q, x, got;
    logic pready, pslverr, ack, e, oe_n, we_n, ras_n, cas_n, cke, sclk, ap;
    logic [1:0] sdram_cs_n, bank_addr, ba_seen;
    logic [26:0] mem_addr, boot_addr;
    logic [5:0] static_cs_n;
    logic [3:0] mask_n, mask_seen;
    logic [7:0] sel_acc;
    logic in_acc = 1'b0;
    logic boot_seen;
    int lowcnt;
    int bad_count = 0;
    int checked = 0;

    memory_bank_boot_config u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_mode_pins(boot_pins),
        .big_endian(big_endian), .mem_data_in(mem_data_in), .req(req),
        .req_write(req_write), .req_byte(req_byte), .req_addr(req_addr),
        .ack(ack), .rdata(rdata), .mem_addr(mem_addr),
        .static_cs_n(static_cs_n), .out_en_n(oe_n), .write_en_n(we_n),
        .sdram_chip_selects_n(sdram_cs_n), .row_strobe_n(ras_n),
        .column_strobe_n(cas_n), .byte_mask_n(mask_n),
        .sdram_bank_addr(bank_addr), .sdram_clk_en(cke), .sdram_clk(sclk),
        .auto_precharge_flag(ap));
    mem_model #(.STATIC_WORD(STATIC_WORD), .SDRAM_WORD(SDRAM_WORD))
        u_mem (.pclk(pclk), .static_cs_n(static_cs_n), .out_en_n(oe_n),
        .sdram_chip_selects_n(sdram_cs_n), .mem_data_in(mem_data_in));

    always #5 pclk = ~pclk;

    // Records what the pins did during one core access
    always @(posedge pclk) begin
        if (in_acc) begin
            sel_acc = sel_acc | ~{sdram_cs_n, static_cs_n};
            if (static_cs_n !== 6'h3f) begin
                mask_seen = mask_n;
                we_seen = we_n;
                lowcnt++;
            end
            if (ras_n === 1'b0 && sdram_cs_n !== 2'h3) begin
                ba_seen = bank_addr;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_seen = 1'b0;
        end else if (!boot_seen && static_cs_n[0] === 1'b0) begin
            boot_seen = 1'b1;
            boot_addr = mem_addr;
        end
    end

    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(string w, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, exp, seen);
        end
    endtask

    task automatic hang(string w);
        bad_count++;
        $display("Error %s expected answer seen timeout", w);
        tally_and_finish();
    endtask

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] rq, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            hang("pready");
        end
        rq = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(string w, logic [7:0] a, logic [31:0] xp);
        logic [31:0] rq;
        logic err;
        apb(1'b0, a, 32'h0, rq, err);
        check(w, rq, xp);
    endtask

    task automatic core(logic [29:0] a, logic b);
        int n;
        n = 0;
        @(posedge pclk);
        req <= 1'b1;
        req_addr <= a;
        req_byte <= b;
        sel_acc = 8'h00;
        lowcnt = 0;
        ba_seen = 'x;
        in_acc = 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (ack !== 1'b1 && n < 200);
        if (n == 200) begin
            hang("ack");
        end
        req <= 1'b0;
        in_acc = 1'b0;
        got = rdata;
    endtask

    task automatic do_reset(logic [1:0] pins);
        int n;
        logic [1:0] w;
        n = 0;
        w = (pins == 2'h1) ? 2'h1 : ((pins == 2'h0) ? 2'h0 : 2'h2);
        @(posedge pclk);
        presetn <= 1'b0;
        boot_pins <= pins;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        do begin
            apb(1'b0, 8'h34, 32'h0, q, e);
            n++;
        end while (q[1:0] !== 2'h3 && n < 20);
        if (n == 20) begin
            hang("boot");
        end
        check("boot address", {5'h0, boot_addr}, 32'h0);
        check("status", q, {26'h0, pins, w, 2'h3});
        check("clock enable", {31'h0, cke}, 32'h1);
    endtask

    initial begin
        do_reset(2'h1);
        rchk("width reset", 8'h00, 32'h0);
        rchk("timing reset", 8'h04, 32'h0000_0700);
        rchk("sdram timing reset", 8'h1c, 32'h0);
        rchk("mode reset", 8'h2c, 32'h0000_0030);
        apb(1'b1, 8'h24, 32'h008e_0459, q, e);
        rchk("refresh", 8'h24, 32'h008e_0459);
        apb(1'b1, 8'h30, 32'h0000_0030, q, e);
        check("second mode error", {31'h0, e}, 32'h0);
        apb(1'b1, 8'h00, 32'h2222_2222, q, e);
        rchk("width", 8'h00, 32'h2222_2220);
        foreach (rows[i]) begin
            apb(1'b1, 8'h28, {29'h0, rows[i].size}, q, e);
            apb(1'b1, 8'h1c, {27'h0, rows[i].four, 4'h0}, q, e);
            apb(1'b1, 8'h20, {27'h0, rows[i].four, 4'h0}, q, e);
            core(rows[i].a, 1'b0);
            check("bank select", {30'h0, ba_seen}, {30'h0, rows[i].ba});
            check("sdram select", {24'h0, sel_acc},
                32'h1 << rows[i].a[29:27]);
            check("sdram data", got, SDRAM_WORD);
        end
        for (int b = 1; b < 6; b++) begin
            apb(1'b1, 8'h00, 32'h2200_0000 | ((b % 3) << (4 * b)), q, e);
            req_write <= (b == 4);
            core({3'(b), 27'h0}, 1'b0);
            check("write strobe", {31'h0, we_seen}, {31'h0, b != 4});
            x = (b % 3 == 0) ? 32'he : ((b % 3 == 1) ? 32'hc : 32'h0);
            check("mask", {28'h0, mask_seen}, x);
            check("static select", {24'h0, sel_acc}, 32'h1 << b);
            check("default cycles", lowcnt, 32'he);
            if (b % 3 == 2) begin
                check("word", got, STATIC_WORD);
            end
        end
        apb(1'b1, 8'h00, 32'h2200_0010, q, e);
        for (int i = 0; i < 4; i++) begin
            big_endian <= i[1];
            repeat (4) @(posedge pclk);
            core({3'h1, 26'h0, i[0]}, 1'b1);
            x = (i[0] ^ i[1]) ? {24'h0, STATIC_WORD[15:8]}
                : {24'h0, STATIC_WORD[7:0]};
            check("lane", {24'h0, got[7:0]}, x);
        end
        apb(1'b1, 8'h00, 32'h2200_0000, q, e);
        foreach (acc_cycles[c]) begin
            apb(1'b1, 8'h08, {21'h0, 3'(c), 8'h0}, q, e);
            core(30'h0800_0000, 1'b0);
            check("access cycles", lowcnt, acc_cycles[c]);
        end
        apb(1'b1, 8'h08, 32'h0000_0700, q, e);
        apb(1'b0, 8'h38, 32'h0, q, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h05, 32'h0, q, e);
        check("unaligned error", {31'h0, e}, 32'h1);
        for (int p = 0; p < 4; p++) begin
            do_reset(2'(p));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
